// File: core/rsxt_pkg.sv
// package for the rotate/swap/xor/direction-load datapath
package rsxt_pkg;
    typedef enum logic [2:0] {
        RSXT_OP_NONE,
        RSXT_OP_ROTATE_RIGHT_CARRY,
        RSXT_OP_NIBBLE_EXCHANGE,
        RSXT_OP_XOR_FILE,
        RSXT_OP_XOR_IMMEDIATE,
        RSXT_OP_PORT_DIRECTION_LOAD
    } rsxt_op_e;

    localparam int unsigned RSXT_DATA_W    = 8;
    localparam int unsigned RSXT_ADDR_W    = 5;
    localparam logic [4:0]  RSXT_ADDR_MAX  = 5'h1F;
    localparam logic [2:0]  RSXT_DIR_SEL_A = 3'h6;
    localparam logic [2:0]  RSXT_DIR_SEL_B = 3'h7;
    localparam logic        RSXT_DEST_ACC  = 1'b0;
    localparam logic        RSXT_DEST_FILE = 1'b1;
    localparam logic [7:0]  RSXT_ACC_RST   = 8'h00;
    localparam logic [4:0]  RSXT_WADDR_RST = 5'h00;
    localparam logic [7:0]  RSXT_WDATA_RST = 8'h00;
    localparam logic [7:0]  RSXT_DIR_RST   = 8'hFF;
    localparam logic        RSXT_FLAG_RST  = 1'b0;
endpackage

// File: core/rsxt_alu.sv
// combinational result and flag logic of the datapath
`timescale 1ns/1ps
module rsxt_alu
    import rsxt_pkg::*;
(
    input  wire rsxt_pkg::rsxt_op_e op,
    input  wire logic [7:0]         acc,
    input  wire logic [7:0]         src,
    input  wire logic [7:0]         imm,
    input  wire logic               carry_in,
    output logic [7:0]              result,
    output logic                    carry_out,
    output logic                    zero_out
);
    always_comb begin
        result    = src;
        carry_out = carry_in;
        case (op)
            RSXT_OP_ROTATE_RIGHT_CARRY: begin
                result    = {carry_in, src[7:1]};
                carry_out = src[0];
            end
            RSXT_OP_NIBBLE_EXCHANGE:     result = {src[3:0], src[7:4]};
            RSXT_OP_XOR_FILE:            result = acc ^ src;
            RSXT_OP_XOR_IMMEDIATE:       result = acc ^ imm;
            RSXT_OP_PORT_DIRECTION_LOAD: result = acc;
            default:                     result = src;
        endcase
        zero_out = (result == 8'h00);
    end
endmodule

// File: core/rsxt_datapath.sv
// execution datapath: rotate, nibble exchange, xor, direction-register load
// Notes on behaviour
// - rotate right moves the addressed file register (0..31) through carry; only carry changes.
// - destination bit 0 writes the accumulator, 1 writes the addressed file register.
// - nibble exchange swaps the two halves of the source; no flag changes.
// - direction load copies accumulator into direction register 6 or 7; flags unchanged.
// - immediate xor combines accumulator with an 8-bit value into accumulator; sets zero.
// - file xor combines accumulator with addressed register, routed by destination; sets zero.
`timescale 1ns/1ps
module rsxt_datapath
    import rsxt_pkg::*;
(
    core_clk,
    srst,
    clk_en,
    op_valid,
    op,
    file_addr,
    dest_sel,
    imm,
    file_rdata,
    file_we_q,
    file_waddr_q,
    file_wdata_q,
    acc_q,
    carry_q,
    zero_q,
    dir_a_q,
    dir_b_q
);
    input  wire logic               core_clk;
    input  wire logic               srst;
    input  wire logic               clk_en;
    input  wire logic               op_valid;
    input  wire rsxt_pkg::rsxt_op_e op;
    input  wire logic [4:0]         file_addr;
    input  wire logic               dest_sel;
    input  wire logic [7:0]         imm;
    input  wire logic [7:0]         file_rdata;
    output logic                    file_we_q;
    output logic [4:0]              file_waddr_q;
    output logic [7:0]              file_wdata_q;
    output logic [7:0]              acc_q;
    output logic                    carry_q;
    output logic                    zero_q;
    output logic [7:0]              dir_a_q;
    output logic [7:0]              dir_b_q;

    logic [7:0] result;
    logic       carry_d;
    logic       zero_d;
    logic       file_dest;
    logic       go;

    rsxt_alu u_alu (
        .op        (op),
        .acc       (acc_q),
        .src       (file_rdata),
        .imm       (imm),
        .carry_in  (carry_q),
        .result    (result),
        .carry_out (carry_d),
        .zero_out  (zero_d)
    );

    // ops that take a destination operand
    function automatic logic has_dest(input rsxt_op_e o);
        return (o == RSXT_OP_ROTATE_RIGHT_CARRY) || (o == RSXT_OP_NIBBLE_EXCHANGE) || (o == RSXT_OP_XOR_FILE);
    endfunction

    assign go        = clk_en && op_valid;
    assign file_dest = has_dest(op) && (dest_sel == RSXT_DEST_FILE);

    // file write port; address above range cannot occur with a 5-bit field
    always_ff @(posedge core_clk) begin
        if (srst) begin
            file_we_q    <= 1'b0;
            file_waddr_q <= RSXT_WADDR_RST;
            file_wdata_q <= RSXT_WDATA_RST;
        end else if (clk_en) begin
            file_we_q <= op_valid && file_dest;
            if (op_valid && file_dest) begin
                file_waddr_q <= file_addr;
                file_wdata_q <= result;
            end
        end
    end

    // accumulator
    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_q <= RSXT_ACC_RST;
        end else if (go) begin
            if (has_dest(op) && dest_sel == RSXT_DEST_ACC) begin
                acc_q <= result;
            end else if (op == RSXT_OP_XOR_IMMEDIATE) begin
                acc_q <= result;
            end
        end
    end

    // carry only moves on rotate
    always_ff @(posedge core_clk) begin
        if (srst) begin
            carry_q <= RSXT_FLAG_RST;
        end else if (go && op == RSXT_OP_ROTATE_RIGHT_CARRY) begin
            carry_q <= carry_d;
        end
    end

    // zero only moves on the two xor forms
    always_ff @(posedge core_clk) begin
        if (srst) begin
            zero_q <= RSXT_FLAG_RST;
        end else if (go && (op == RSXT_OP_XOR_FILE || op == RSXT_OP_XOR_IMMEDIATE)) begin
            zero_q <= zero_d;
        end
    end

    // direction registers; other selectors are ignored, reset to all inputs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dir_a_q <= RSXT_DIR_RST;
            dir_b_q <= RSXT_DIR_RST;
        end else if (go && op == RSXT_OP_PORT_DIRECTION_LOAD) begin
            if (file_addr[2:0] == RSXT_DIR_SEL_A && file_addr[4:3] == 2'h0) begin
                dir_a_q <= acc_q;
            end
            if (file_addr[2:0] == RSXT_DIR_SEL_B && file_addr[4:3] == 2'h0) begin
                dir_b_q <= acc_q;
            end
        end
    end

    chk_rotate_carry: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_ROTATE_RIGHT_CARRY |=> carry_q == $past(file_rdata[0]))
        else $error("rotate carry wrong");
    chk_rotate_result: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_ROTATE_RIGHT_CARRY && dest_sel == RSXT_DEST_ACC
        |=> acc_q == {$past(carry_q), $past(file_rdata[7:1])})
        else $error("rotate result wrong");
    chk_dest_file: assert property (@(posedge core_clk) disable iff (srst)
        go && has_dest(op) && dest_sel == RSXT_DEST_FILE |=> file_we_q && $stable(acc_q))
        else $error("file destination wrong");
    chk_swap_flags: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_NIBBLE_EXCHANGE |=> $stable(carry_q) && $stable(zero_q))
        else $error("swap touched flags");
    chk_swap_data: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_NIBBLE_EXCHANGE && dest_sel == RSXT_DEST_FILE
        |=> file_wdata_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap data wrong");
    chk_dir_load: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_PORT_DIRECTION_LOAD && file_addr == 5'h06
        |=> dir_a_q == $past(acc_q) && $stable(carry_q) && $stable(zero_q))
        else $error("direction load wrong");
    chk_xor_imm: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_XOR_IMMEDIATE |=> acc_q == ($past(acc_q) ^ $past(imm)) && zero_q == (acc_q == 8'h00))
        else $error("immediate xor wrong");
    chk_xor_file: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_XOR_FILE && dest_sel == RSXT_DEST_FILE
        |=> file_wdata_q == ($past(acc_q) ^ $past(file_rdata)) && zero_q == (file_wdata_q == 8'h00))
        else $error("file xor wrong");
    chk_freeze: assert property (@(posedge core_clk) disable iff (srst)
        !clk_en |=> $stable(acc_q) && $stable(carry_q) && $stable(zero_q))
        else $error("state moved while disabled");

    // operands are taken one edge back, so file_rdata must stand together with the op
    chk_rotate_file: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_ROTATE_RIGHT_CARRY && dest_sel == RSXT_DEST_FILE
        |=> file_wdata_q == {$past(carry_q), $past(file_rdata[7:1])})
        else $error("rotate file result wrong");
    chk_rotate_zero: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_ROTATE_RIGHT_CARRY |=> $stable(zero_q))
        else $error("rotate touched zero");
    chk_dest_acc: assert property (@(posedge core_clk) disable iff (srst)
        go && has_dest(op) && dest_sel == RSXT_DEST_ACC |=> !file_we_q)
        else $error("accumulator destination wrote file");
    chk_file_addr: assert property (@(posedge core_clk) disable iff (srst)
        go && has_dest(op) && dest_sel == RSXT_DEST_FILE
        |=> file_waddr_q == $past(file_addr))
        else $error("file write address wrong");
    chk_swap_acc: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_NIBBLE_EXCHANGE && dest_sel == RSXT_DEST_ACC
        |=> acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap into accumulator wrong");
    chk_dir_load_b: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_PORT_DIRECTION_LOAD && file_addr == 5'h07
        |=> dir_b_q == $past(acc_q) && $stable(dir_a_q) && $stable(acc_q))
        else $error("second direction load wrong");
    chk_dir_refused: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_PORT_DIRECTION_LOAD && file_addr != 5'h06 && file_addr != 5'h07
        |=> $stable(dir_a_q) && $stable(dir_b_q))
        else $error("direction load with bad selector");
    chk_dir_no_file: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_PORT_DIRECTION_LOAD |=> !file_we_q && $stable(acc_q))
        else $error("direction load wrote data");
    chk_xor_imm_side: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_XOR_IMMEDIATE |=> $stable(carry_q) && !file_we_q)
        else $error("immediate xor side effect");
    chk_xor_file_acc: assert property (@(posedge core_clk) disable iff (srst)
        go && op == RSXT_OP_XOR_FILE && dest_sel == RSXT_DEST_ACC
        |=> acc_q == ($past(acc_q) ^ $past(file_rdata)) && zero_q == (acc_q == 8'h00))
        else $error("file xor into accumulator wrong");
    chk_carry_hold: assert property (@(posedge core_clk) disable iff (srst)
        go && op != RSXT_OP_ROTATE_RIGHT_CARRY |=> $stable(carry_q))
        else $error("carry moved outside rotate");
    chk_zero_hold: assert property (@(posedge core_clk) disable iff (srst)
        go && op != RSXT_OP_XOR_FILE && op != RSXT_OP_XOR_IMMEDIATE
        |=> $stable(zero_q))
        else $error("zero moved outside xor");
    chk_idle_hold: assert property (@(posedge core_clk) disable iff (srst)
        clk_en && !op_valid |=> !file_we_q && $stable(acc_q) && $stable(carry_q) && $stable(zero_q))
        else $error("state moved while idle");
    chk_freeze_out: assert property (@(posedge core_clk) disable iff (srst)
        !clk_en |=> $stable(file_we_q) && $stable(file_waddr_q) && $stable(file_wdata_q)
        && $stable(dir_a_q) && $stable(dir_b_q))
        else $error("outputs moved while disabled");
    chk_reset_state: assert property (@(posedge core_clk)
        srst |=> acc_q == RSXT_ACC_RST && carry_q == RSXT_FLAG_RST && zero_q == RSXT_FLAG_RST
        && !file_we_q && dir_a_q == RSXT_DIR_RST && dir_b_q == RSXT_DIR_RST)
        else $error("reset state wrong");
endmodule

// File: verification/tb.sv
// self-checking testbench for the rotate/swap/xor/direction-load datapath
`timescale 1ns/1ps
module tb;
    import rsxt_pkg::*;
    logic       core_clk   = 1'b0;
    logic       srst       = 1'b1;
    logic       clk_en     = 1'b1;
    logic       op_valid   = 1'b0;
    rsxt_op_e   op         = RSXT_OP_NONE;
    logic [4:0] file_addr  = 5'h00;
    logic       dest_sel   = 1'b0;
    logic [7:0] imm        = 8'h00;
    logic [7:0] file_rdata = 8'h00;
    logic       file_we_q;
    logic [4:0] file_waddr_q;
    logic [7:0] file_wdata_q, acc_q, dir_a_q, dir_b_q;
    logic       carry_q, zero_q;
    int         n_fail      = 0;
    int         checks_done = 0;

    rsxt_datapath uut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .op_valid(op_valid), .op(op),
        .file_addr(file_addr), .dest_sel(dest_sel), .imm(imm), .file_rdata(file_rdata),
        .file_we_q(file_we_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q),
        .acc_q(acc_q), .carry_q(carry_q), .zero_q(zero_q), .dir_a_q(dir_a_q), .dir_b_q(dir_b_q));

    always #5 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // flags and accumulator together, the common case after every op
    task automatic chk_st(input logic [7:0] a, input logic c, input logic z);
        chk("acc", a, acc_q);
        chk("carry", {7'h00, c}, {7'h00, carry_q});
        chk("zero", {7'h00, z}, {7'h00, zero_q});
    endtask

    // called at a falling edge; returns one falling edge later with results settled;
    // op_valid is left high so that a following op can go back to back
    task automatic run(input rsxt_op_e o, input logic [4:0] a, input logic d, input logic [7:0] k, input logic [7:0] r);
        op = o;
        file_addr = a;
        dest_sel = d;
        imm = k;
        file_rdata = r;
        op_valid = 1'b1;
        @(negedge core_clk);
    endtask

    task automatic chk_wr(input logic [4:0] a, input logic [7:0] v);
        chk("file_we", 8'h01, {7'h00, file_we_q});
        chk("file_waddr", {3'h0, a}, {3'h0, file_waddr_q});
        chk("file_wdata", v, file_wdata_q);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic test_xor_imm;
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b1, 8'hA5, 8'h5A);
        chk_st(8'hA5, 1'b0, 1'b0);
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hA5, 8'h00);
        chk_st(8'h00, 1'b0, 1'b1);
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hFF, 8'h00);
        chk_st(8'hFF, 1'b0, 1'b0);
        $display("test xor_imm done");
    endtask

    task automatic test_rotate;
        run(RSXT_OP_ROTATE_RIGHT_CARRY, 5'h1F, 1'b0, 8'h00, 8'h03);
        chk_st(8'h01, 1'b1, 1'b0);
        run(RSXT_OP_ROTATE_RIGHT_CARRY, 5'h1F, 1'b1, 8'h00, 8'h02);
        chk_st(8'h01, 1'b0, 1'b0);
        chk_wr(5'h1F, 8'h81);
        op_valid = 1'b0;
        @(negedge core_clk);
        chk("file_we", 8'h00, {7'h00, file_we_q});
        $display("test rotate done");
    endtask

    task automatic test_swap;
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'h01, 8'h00);
        run(RSXT_OP_NIBBLE_EXCHANGE, 5'h0A, 1'b1, 8'h00, 8'h3C);
        chk_wr(5'h0A, 8'hC3);
        run(RSXT_OP_NIBBLE_EXCHANGE, 5'h0A, 1'b0, 8'h00, 8'h3C);
        chk_st(8'hC3, 1'b0, 1'b1);
        $display("test swap done");
    endtask

    task automatic test_dir;
        run(RSXT_OP_PORT_DIRECTION_LOAD, 5'h06, 1'b0, 8'h00, 8'h00);
        chk("dir_a", 8'hC3, dir_a_q);
        chk("dir_b", 8'hFF, dir_b_q);
        run(RSXT_OP_PORT_DIRECTION_LOAD, 5'h05, 1'b0, 8'h00, 8'h00);
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hCC, 8'h00);
        run(RSXT_OP_PORT_DIRECTION_LOAD, 5'h07, 1'b0, 8'h00, 8'h00);
        chk("dir_a", 8'hC3, dir_a_q);
        chk("dir_b", 8'h0F, dir_b_q);
        // selectors that only share low bits with 6 or 7 must be refused
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hFF, 8'h00);
        run(RSXT_OP_PORT_DIRECTION_LOAD, 5'h0E, 1'b0, 8'h00, 8'h00);
        run(RSXT_OP_PORT_DIRECTION_LOAD, 5'h0F, 1'b0, 8'h00, 8'h00);
        chk("dir_a", 8'hC3, dir_a_q);
        chk("dir_b", 8'h0F, dir_b_q);
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hFF, 8'h00);
        chk_st(8'h0F, 1'b0, 1'b0);
        $display("test dir done");
    endtask

    task automatic test_xor_file;
        run(RSXT_OP_XOR_FILE, 5'h03, 1'b1, 8'h00, 8'h0F);
        chk_wr(5'h03, 8'h00);
        chk_st(8'h0F, 1'b0, 1'b1);
        run(RSXT_OP_XOR_FILE, 5'h03, 1'b0, 8'h00, 8'hF0);
        chk_st(8'hFF, 1'b0, 1'b0);
        clk_en = 1'b0;
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'hFF, 8'h00);
        clk_en = 1'b1;
        chk_st(8'hFF, 1'b0, 1'b0);
        $display("test xor_file done");
    endtask

    // reset in mid-run with clk_en low: reset must not wait for the enable
    task automatic test_midrun_reset;
        op_valid = 1'b0;
        @(negedge core_clk);
        clk_en = 1'b0;
        srst = 1'b1;
        @(negedge core_clk);
        srst = 1'b0;
        clk_en = 1'b1;
        chk_st(8'h00, 1'b0, 1'b0);
        chk("dir_a", 8'hFF, dir_a_q);
        chk("dir_b", 8'hFF, dir_b_q);
        chk("file_waddr", 8'h00, {3'h0, file_waddr_q});
        chk("file_we", 8'h00, {7'h00, file_we_q});
        run(RSXT_OP_XOR_IMMEDIATE, 5'h00, 1'b0, 8'h5A, 8'h00);
        chk_st(8'h5A, 1'b0, 1'b0);
        $display("test midrun_reset done");
    endtask

    // whole run needs under 100 cycles; 2000 leaves ample margin
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        chk_st(8'h00, 1'b0, 1'b0);
        chk("dir_a", 8'hFF, dir_a_q);
        test_xor_imm();
        test_rotate();
        test_swap();
        test_dir();
        test_xor_file();
        test_midrun_reset();
        tally_and_finish();
    end
endmodule
